// >>> board_model.sv
// Board model: resolves port A pin levels from device drive, pullups and external parties
`timescale 1ns/1ps
module board_model (
  // Clock for the floating-pin pattern
  input wire logic clk,
  // Device pin controls
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] pa_pu,
  // External parties pulling pins low (debug host, reset switch)
  input wire logic [7:0] host_low,
  // Resolved pin levels
  output logic [7:0] pa_in
);
  logic float_q = 1'b0;
  // An undriven pin without pullup wanders instead of holding a settled value
  always @(posedge clk) float_q <= !float_q;
  // Wired resolution: any low driver wins, then an active high or a pullup
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (host_low[i] || (pa_oe[i] && !pa_out[i])) pa_in[i] = 1'b0;
      else if (pa_oe[i] || pa_pu[i]) pa_in[i] = 1'b1;
      else pa_in[i] = float_q ^ i[0];
    end
  end
endmodule : board_model

// >>> debug_bit_shifter.sv
// Single-wire debug byte transmitter with speedup pulses
`timescale 1ns/1ps
module debug_bit_shifter (
  // Clock, reset and debug clock enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic tick,
  // Control side
  debug_link_if.lnk link
);
  typedef enum logic {
    IDLE = 1'b0,
    SHIFT = 1'b1
  } shift_state_t;

  shift_state_t state_q;
  logic [7:0] shreg_q;
  logic [3:0] tick_cnt_q;
  logic [2:0] bit_cnt_q;
  logic [3:0] low_len;

  // A one is a short low pulse, a zero a long one
  assign low_len = shreg_q[7] ? pin_function_pkg::LOW_TICKS_ONE
                              : pin_function_pkg::LOW_TICKS_ZERO;
  assign link.busy = (state_q == SHIFT);

  // Each bit spans sixteen debug clock ticks, msb first
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= IDLE;
      shreg_q <= 8'h00;
      tick_cnt_q <= 4'h0;
      bit_cnt_q <= 3'h0;
    end else begin
      case (state_q)
        IDLE: begin
          if (link.start) begin
            state_q <= SHIFT;
            shreg_q <= link.data;
            tick_cnt_q <= 4'h0;
            bit_cnt_q <= 3'h0;
          end
        end
        SHIFT: begin
          if (tick) begin
            tick_cnt_q <= tick_cnt_q + 4'h1;
            if (tick_cnt_q == pin_function_pkg::BIT_TICKS_LAST) begin
              shreg_q <= {shreg_q[6:0], 1'b0};
              bit_cnt_q <= bit_cnt_q + 3'h1;
              if (bit_cnt_q == pin_function_pkg::BITS_LAST) begin
                state_q <= IDLE;
              end
            end
          end
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  // Low phase, then one tick driven high to sharpen the rising edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link.drive_low <= 1'b0;
      link.drive_high <= 1'b0;
    end else begin
      link.drive_low <= (state_q == SHIFT) && (tick_cnt_q < low_len);
      link.drive_high <= (state_q == SHIFT) && (tick_cnt_q == low_len);
    end
  end
endmodule : debug_bit_shifter

// >>> debug_link_if.sv
// Interface between the control logic and the debug bit shifter
`timescale 1ns/1ps
interface debug_link_if;
  logic start;
  logic [7:0] data;
  logic busy;
  logic drive_low;
  logic drive_high;
  modport ctl (output start, output data, input busy, input drive_low, input drive_high);
  modport lnk (input start, input data, output busy, output drive_low, output drive_high);
endinterface : debug_link_if

// >>> pin_function_control.sv
// Pin-function control: shared reset pin, debug pin, port A pins, high drive
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
// Operation
// - Enabled reset pin driven low during internal reset
// - Low on enabled reset pin resets device
// - Power-on: reset function, pullup, hysteresis input
// - Only power-on restores pin function selection (code: any device reset restores debug, comparator and serial-bus enables)
// - Interrupt mode feeds interrupt and branch level
// - Debug pin sampled as mode select
// - Debug role follows internal reset release
// - Debug role keeps pullup and driver
// - Debug enable set on reset, software clears
// - Undriven mode pin gives normal mode (code samples it at power-on while the bit 4 pullup is still off)
// - Sixteen debug clocks per link bit
// - Debug clock up to bus rate scales timing
// - Pseudo open-drain link with speedup pulses
// - Per-bit pullup on input port bits
// - Output bits lose pullup except serial bus
// - Debug port bit output-only, no pullup
// - Serial-bus bits drive low only
// - Serial-bus pullup cut while output low
// - High-drive bits strong only when enabled
// - Any reset: inputs, pullups off
module pin_function_control (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic arst_n,
  // Internal reset sources and device reset
  input wire logic int_reset_req,
  input wire logic dbg_force_reset,
  output logic sys_reset,
  // Port A pins, bit 4 debug pin, bit 5 shared reset pin
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  output logic [7:0] pa_pu,
  // Alternate functions
  input wire logic comparator_output,
  output logic irq_request,
  output logic branch_pin_level,
  output logic background_mode,
  output logic [7:0] high_drive_en,
  // AXI4-Lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  localparam int DBG = pin_function_pkg::DEBUG_BIT;
  localparam int SHR = pin_function_pkg::SHARED_RESET_BIT;

  logic [7:0] pa_meta_q;
  logic [7:0] pa_sync_q;
  logic int_src_q;
  logic dbg_en_q;
  logic rst_fn_q;
  logic cmp_en_q;
  logic sb_en_q;
  logic [7:0] data_q;
  logic [7:0] dir_q;
  logic [7:0] pue_q;
  logic [7:0] div_q;
  logic [7:0] div_cnt_q;
  logic mode_win_q;
  logic [7:0] awaddr_q;
  logic aw_held_q;
  logic [31:0] wdata_q;
  logic w_en_q;
  logic w_held_q;
  logic do_write;
  logic wr_ok;
  logic dbg_tick;
  logic pin_reset;
  debug_link_if link ();

  // Pin levels come from outside the clock domain; no reset, so the second flop already holds the
  // mode pin at the first edge after power-on release, a floating level if undriven as reset leaves bit 4 without pullup
  always_ff @(posedge clk) begin
    pa_meta_q <= pa_in;
    pa_sync_q <= pa_meta_q;
  end

  // Low on the pin resets the device only while the reset function owns it
  assign pin_reset = rst_fn_q && !pa_sync_q[SHR];

  // Device reset and the record of internal sources that drive the pin
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sys_reset <= 1'b0;
      int_src_q <= 1'b0;
    end else begin
      sys_reset <= int_reset_req || dbg_force_reset || pin_reset;
      int_src_q <= int_reset_req || dbg_force_reset;
    end
  end

  // Mode select window opens at power-on and on a debug force reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_win_q <= 1'b1;
      background_mode <= 1'b0;
    end else if (dbg_force_reset) begin
      mode_win_q <= 1'b1;
    end else if (mode_win_q && !sys_reset) begin
      mode_win_q <= 1'b0;
      background_mode <= !pa_sync_q[DBG];
    end
  end

  // Write handshake: address and data may arrive in either order
  assign do_write = aw_held_q && w_held_q && !s_bvalid;
  assign s_awready = !aw_held_q;
  assign s_wready = !w_held_q;
  assign wr_ok = (awaddr_q[7:2] <= pin_function_pkg::OFS_DEBUG_DIV[7:2]) &&
                 (awaddr_q[1:0] == 2'h0);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      w_en_q <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= pin_function_pkg::RESP_OKAY;
    end else begin
      if (s_awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_awaddr;
      end
      if (s_wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        wdata_q <= s_wdata;
        w_en_q <= s_wstrb[0];
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_ok ? pin_function_pkg::RESP_OKAY : pin_function_pkg::RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // Option bits; the reset pin selection survives every reset but power-on
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dbg_en_q <= pin_function_pkg::SYS_OPTIONS_RESET[pin_function_pkg::DEBUG_PIN_ENABLE];
      rst_fn_q <= pin_function_pkg::SYS_OPTIONS_RESET[pin_function_pkg::RESET_PIN_ENABLE];
      cmp_en_q <= pin_function_pkg::SYS_OPTIONS_RESET[pin_function_pkg::CMP_OUT_ENABLE];
      sb_en_q <= pin_function_pkg::SYS_OPTIONS_RESET[pin_function_pkg::SERIAL_BUS_ENABLE];
    end else if (sys_reset) begin
      dbg_en_q <= 1'b1;
      cmp_en_q <= 1'b0;
      sb_en_q <= 1'b0;
    end else if (do_write && w_en_q && awaddr_q == pin_function_pkg::OFS_SYS_OPTIONS) begin
      dbg_en_q <= wdata_q[pin_function_pkg::DEBUG_PIN_ENABLE];
      rst_fn_q <= wdata_q[pin_function_pkg::RESET_PIN_ENABLE];
      cmp_en_q <= wdata_q[pin_function_pkg::CMP_OUT_ENABLE];
      sb_en_q <= wdata_q[pin_function_pkg::SERIAL_BUS_ENABLE];
    end
  end

  // Port configuration returns to inputs without pullups on any reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_q <= pin_function_pkg::PORT_RESET;
      dir_q <= pin_function_pkg::PORT_RESET;
      pue_q <= pin_function_pkg::PORT_RESET;
      high_drive_en <= pin_function_pkg::PORT_RESET;
      div_q <= pin_function_pkg::DEBUG_DIV_RESET;
    end else if (sys_reset) begin
      data_q <= pin_function_pkg::PORT_RESET;
      dir_q <= pin_function_pkg::PORT_RESET;
      pue_q <= pin_function_pkg::PORT_RESET;
      high_drive_en <= pin_function_pkg::PORT_RESET;
    end else if (do_write && w_en_q) begin
      case (awaddr_q)
        pin_function_pkg::OFS_PORT_DATA: data_q <= wdata_q[7:0];
        pin_function_pkg::OFS_PORT_DIR: dir_q <= wdata_q[7:0];
        pin_function_pkg::OFS_PORT_PULLUP: pue_q <= wdata_q[7:0];
        pin_function_pkg::OFS_HIGH_DRIVE: high_drive_en <= wdata_q[7:0];
        pin_function_pkg::OFS_DEBUG_DIV: div_q <= wdata_q[7:0];
        default: data_q <= data_q;
      endcase
    end
  end

  // A byte is sent only while the pin belongs to the link and it is idle
  assign link.start = do_write && w_en_q && !sys_reset && dbg_en_q && !link.busy &&
                      awaddr_q == pin_function_pkg::OFS_DEBUG_TX;
  assign link.data = wdata_q[7:0];

  // Debug clock enable; a divisor of zero runs the link at bus rate
  assign dbg_tick = (div_cnt_q == div_q);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_q <= 8'h00;
    end else if (dbg_tick) begin
      div_cnt_q <= 8'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

  debug_bit_shifter u_shifter (
    .clk(clk),
    .arst_n(arst_n),
    .tick(dbg_tick),
    .link(link)
  );

  // Pin drive, enable and pullup per bit, all from flip-flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pa_out <= 8'h00;
      pa_oe <= 8'h00;
      pa_pu <= 8'h20;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (i == SHR && rst_fn_q) begin
          pa_out[i] <= 1'b0;
          pa_oe[i] <= int_src_q;
          pa_pu[i] <= 1'b1;
        end else if (i == DBG) begin
          if (dbg_en_q || mode_win_q) begin
            // Link pulls low, briefly drives high, then releases
            pa_out[i] <= link.drive_high;
            pa_oe[i] <= !mode_win_q && (link.drive_low || link.drive_high);
            pa_pu[i] <= 1'b1;
          end else begin
            pa_out[i] <= cmp_en_q ? comparator_output : data_q[i];
            pa_oe[i] <= 1'b1;
            pa_pu[i] <= 1'b0;
          end
        end else if (i == pin_function_pkg::OD_DATA_BIT ||
                     i == pin_function_pkg::OD_CLOCK_BIT) begin
          pa_out[i] <= 1'b0;
          pa_oe[i] <= dir_q[i] && !data_q[i];
          // Pullup kept for the serial bus but dropped to save power when low
          pa_pu[i] <= pue_q[i] && (!dir_q[i] || (sb_en_q && data_q[i]));
        end else begin
          pa_out[i] <= data_q[i];
          pa_oe[i] <= dir_q[i];
          pa_pu[i] <= pue_q[i] && !dir_q[i];
        end
      end
    end
  end

  // Interrupt and branch level follow the shared pin when it is not a reset pin
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_request <= 1'b0;
      branch_pin_level <= 1'b1;
    end else begin
      irq_request <= !rst_fn_q && !pa_sync_q[SHR];
      branch_pin_level <= rst_fn_q ? 1'b1 : pa_sync_q[SHR];
    end
  end

  // Read channel answers one cycle after the address is taken
  assign s_arready = !s_rvalid;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= pin_function_pkg::RESP_OKAY;
    end else if (s_arvalid && !s_rvalid) begin
      s_rvalid <= 1'b1;
      s_rresp <= pin_function_pkg::RESP_OKAY;
      case (s_araddr)
        pin_function_pkg::OFS_SYS_OPTIONS:
          s_rdata <= {28'h0000000, sb_en_q, cmp_en_q, rst_fn_q, dbg_en_q};
        pin_function_pkg::OFS_PORT_DATA:
          s_rdata <= {24'h000000, (data_q & dir_q) | (pa_sync_q & ~dir_q)};
        pin_function_pkg::OFS_PORT_DIR: s_rdata <= {24'h000000, dir_q};
        pin_function_pkg::OFS_PORT_PULLUP: s_rdata <= {24'h000000, pue_q};
        pin_function_pkg::OFS_HIGH_DRIVE: s_rdata <= {24'h000000, high_drive_en};
        pin_function_pkg::OFS_DEBUG_TX: s_rdata <= 32'h0000_0000;
        pin_function_pkg::OFS_DEBUG_DIV: s_rdata <= {24'h000000, div_q};
        pin_function_pkg::OFS_STATUS:
          s_rdata <= {28'h0000000, link.busy, pa_sync_q[DBG], pa_sync_q[SHR],
                      background_mode};
        default: begin
          s_rdata <= 32'h0000_0000;
          s_rresp <= pin_function_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end
endmodule : pin_function_control

// >>> pin_function_control_monitor.sv
// Checker for the pin-function control outputs
`timescale 1ns/1ps
module pin_function_control_monitor (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic arst_n,
  // Reset sources and device reset
  input wire logic int_reset_req,
  input wire logic dbg_force_reset,
  input wire logic sys_reset,
  // Pin controls and alternate functions
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] pa_pu,
  input wire logic irq_request,
  input wire logic branch_pin_level,
  input wire logic background_mode,
  input wire logic [7:0] high_drive_en
);
  logic [1:0] up_q;
  logic [3:0] age_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Edges since power-on release; pin flops need two edges to leave reset values
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  // Age since the last reset pulse, bounds the mode sampling window
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) age_q <= 4'h0;
    else if (dbg_force_reset || sys_reset) age_q <= 4'h0;
    else if (age_q != 4'hf) age_q <= age_q + 4'h1;
  end
  // Debug pin let go after a link drive phase
  sequence release_s;
    $fell(pa_oe[4]) && $past(pa_pu[4]);
  endsequence
  AST_SOFT_RESET: assert property ((int_reset_req || dbg_force_reset) |=> sys_reset)
    else $error("device reset did not follow an internal reset source");
  AST_OD_NO_HIGH: assert property (((pa_oe & pa_out) & 8'h0c) == 8'h00)
    else $error("serial-bus pin driven high");
  AST_OD_PULL_CUT: assert property (((pa_oe & pa_pu) & 8'h0c) == 8'h00)
    else $error("serial-bus pullup on while driving low");
  AST_OUT_NO_PULL: assert property (((pa_oe & pa_pu) & 8'hc3) == 8'h00)
    else $error("pullup left on an output bit");
  AST_DEBUG_PULL: assert property (up_q == 2'h3 |-> pa_pu[4] || pa_oe[4])
    else $error("debug pin neither pulled up nor driven as port output");
  AST_IRQ_LEVEL: assert property (irq_request |-> !branch_pin_level)
    else $error("interrupt request with shared pin level high");
  AST_MODE_WINDOW: assert property ($changed(background_mode) && up_q == 2'h3 |-> age_q < 4'h4)
    else $error("operating mode changed outside a reset window");
  AST_RESET_IDLE: assert property (sys_reset |-> ##[1:3]
    (((pa_oe | pa_pu) & 8'hcf) == 8'h00 && high_drive_en == 8'h00))
    else $error("port pins not idle after device reset");
  AST_SPEEDUP: assert property (release_s |-> $past(pa_out[4]))
    else $error("debug pin released without a high speedup pulse");
endmodule : pin_function_control_monitor

// >>> pin_function_control_tb.sv
// Self-checking testbench for the pin-function control block
`timescale 1ns/1ps
module pin_function_control_tb;
  logic clk, arst_n, int_reset_req, dbg_force_reset, sys_reset, comparator_output;
  logic irq_request, branch_pin_level, background_mode;
  logic [7:0] pa_in, pa_out, pa_oe, pa_pu, high_drive_en, host_low, s_awaddr, s_araddr;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp;
  int err_count, cmp_count, l1, p1, l2, p2;
  pin_function_control u_pin_function_control (.clk(clk), .arst_n(arst_n),
    .int_reset_req(int_reset_req), .dbg_force_reset(dbg_force_reset), .sys_reset(sys_reset),
    .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pa_pu(pa_pu),
    .comparator_output(comparator_output), .irq_request(irq_request),
    .branch_pin_level(branch_pin_level), .background_mode(background_mode),
    .high_drive_en(high_drive_en), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));
  board_model u_board_model (.clk(clk), .pa_out(pa_out), .pa_oe(pa_oe), .pa_pu(pa_pu),
    .host_low(host_low), .pa_in(pa_in));
  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // Every wait is bounded; running out ends the run
  task automatic bound(input int n);
    if (n >= 64) begin
      err_count++;
      give_verdict();
    end
  endtask : bound
  // Bus write; ready is sampled mid-cycle, the handshake lands on the next rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw_hit, w_hit, b_hit;
    logic [1:0] r;
    n = 0;
    @(posedge clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(negedge clk);
      aw_hit = s_awvalid && s_awready;
      w_hit = s_wvalid && s_wready;
      b_hit = s_bvalid;
      r = s_bresp;
      @(posedge clk);
      if (aw_hit) s_awvalid <= 1'b0;
      if (w_hit) s_wvalid <= 1'b0;
      n++;
      bound(n);
    end while (!b_hit);
    s_bready <= 1'b0;
    check(r, er);
    @(negedge clk);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic ar_hit, r_hit;
    logic [31:0] d;
    logic [1:0] r;
    n = 0;
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(negedge clk);
      ar_hit = s_arvalid && s_arready;
      r_hit = s_rvalid;
      d = s_rdata;
      r = s_rresp;
      @(posedge clk);
      if (ar_hit) s_arvalid <= 1'b0;
      n++;
      bound(n);
    end while (!r_hit);
    s_rready <= 1'b0;
    check(d, ed);
    check(r, er);
  endtask : axi_rd
  // Power-on reset, optionally with the debug host holding pins low across release
  task automatic por(input logic [7:0] hl);
    @(posedge clk);
    host_low <= hl;
    arst_n <= 1'b0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    host_low <= 8'h00;
    @(negedge clk);
  endtask : por
  task automatic wait_rst(input logic v);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      bound(n);
    end while (sys_reset !== v);
  endtask : wait_rst
  // Time the next debug link low phase and the span from its start to the start of the following one
  task automatic measure(output int len, output int gap);
    int n;
    n = 0;
    len = 0;
    while (!(pa_oe[4] && !pa_out[4])) begin @(negedge clk); n++; bound(n); end
    while (pa_oe[4] && !pa_out[4]) begin @(negedge clk); len++; bound(len); end
    gap = len;
    while (!(pa_oe[4] && !pa_out[4])) begin @(negedge clk); gap++; bound(gap); end
  endtask : measure
  // Main sequence
  initial begin
    err_count = 0; cmp_count = 0; arst_n = 1'b0; int_reset_req = 1'b0;
    dbg_force_reset = 1'b0; comparator_output = 1'b0; host_low = 8'h00;
    s_awaddr = 8'h00; s_araddr = 8'h00; s_wdata = 32'h0; s_wstrb = 4'hf;
    s_awvalid = 1'b0; s_wvalid = 1'b0; s_bready = 1'b0; s_arvalid = 1'b0; s_rready = 1'b0;
    por(8'h00);
    check(background_mode, 1'b0);
    check({pa_oe, pa_pu, high_drive_en}, 24'h003000);
    axi_rd(pin_function_pkg::OFS_SYS_OPTIONS, 32'h3, pin_function_pkg::RESP_OKAY);
    axi_rd(8'h3c, 32'h0, pin_function_pkg::RESP_SLVERR);
    axi_wr(8'h3c, 32'hff, pin_function_pkg::RESP_SLVERR);
    // Internal reset source drives the shared pin low
    int_reset_req <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check({sys_reset, pa_oe[5], pa_out[5]}, 3'b110);
    @(posedge clk);
    int_reset_req <= 1'b0;
    wait_rst(1'b0);
    // External low on the shared pin resets the device
    @(posedge clk);
    host_low <= 8'h20;
    wait_rst(1'b1);
    check(sys_reset, 1'b1);
    host_low <= 8'h00;
    wait_rst(1'b0);
    // Pullups follow direction, serial-bus bits stay open-drain
    axi_wr(pin_function_pkg::OFS_PORT_PULLUP, 32'hff, pin_function_pkg::RESP_OKAY);
    check(pa_pu, 8'hff);
    axi_wr(pin_function_pkg::OFS_PORT_DIR, 32'hff, pin_function_pkg::RESP_OKAY);
    check({pa_pu, pa_oe}, 16'h30cf);
    axi_wr(pin_function_pkg::OFS_SYS_OPTIONS, 32'h0b, pin_function_pkg::RESP_OKAY);
    axi_wr(pin_function_pkg::OFS_PORT_DATA, 32'h1c, pin_function_pkg::RESP_OKAY);
    check({pa_pu, pa_oe}, 16'h3cc3);
    check(pa_out & 8'hef, 8'h00);
    // Clearing debug enable frees the output-only port function
    axi_wr(pin_function_pkg::OFS_SYS_OPTIONS, 32'h02, pin_function_pkg::RESP_OKAY);
    check({pa_oe[4], pa_pu[4], pa_out[4]}, 3'b101);
    axi_wr(pin_function_pkg::OFS_SYS_OPTIONS, 32'h06, pin_function_pkg::RESP_OKAY);
    check(pa_out[4], 1'b0);
    axi_wr(pin_function_pkg::OFS_HIGH_DRIVE, 32'ha5, pin_function_pkg::RESP_OKAY);
    check(high_drive_en, 8'ha5);
    axi_rd(pin_function_pkg::OFS_HIGH_DRIVE, 32'ha5, pin_function_pkg::RESP_OKAY);
    // Shared pin as interrupt input; a later soft reset keeps its function
    axi_wr(pin_function_pkg::OFS_SYS_OPTIONS, 32'h00, pin_function_pkg::RESP_OKAY);
    axi_wr(pin_function_pkg::OFS_PORT_DIR, 32'h00, pin_function_pkg::RESP_OKAY);
    host_low <= 8'h20;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check({irq_request, branch_pin_level, sys_reset}, 3'b100);
    @(posedge clk);
    host_low <= 8'h00;
    int_reset_req <= 1'b1;
    wait_rst(1'b1);
    @(posedge clk);
    int_reset_req <= 1'b0;
    wait_rst(1'b0);
    axi_rd(pin_function_pkg::OFS_SYS_OPTIONS, 32'h1, pin_function_pkg::RESP_OKAY);
    // Debug byte at half bus rate: 0 bit then 1 bit, 16 ticks each
    axi_wr(pin_function_pkg::OFS_DEBUG_DIV, 32'h1, pin_function_pkg::RESP_OKAY);
    axi_wr(pin_function_pkg::OFS_DEBUG_TX, 32'h40, pin_function_pkg::RESP_OKAY);
    // First bit is skipped: its length depends on the free-running divider phase
    measure(l1, p1);
    measure(l2, p2);
    measure(l1, p1);
    check({l1[7:0], p1[7:0], l2[7:0], p2[7:0]}, 32'h1a200820);
    repeat (256) @(posedge clk);
    // Forced debug reset with the host holding the mode pin low
    host_low <= 8'h10;
    dbg_force_reset <= 1'b1;
    repeat (4) @(posedge clk);
    dbg_force_reset <= 1'b0;
    repeat (6) @(posedge clk);
    host_low <= 8'h00;
    @(negedge clk);
    check({background_mode, pa_pu[4]}, 2'b11);
    por(8'h10);
    check(background_mode, 1'b1);
    axi_rd(pin_function_pkg::OFS_SYS_OPTIONS, 32'h3, pin_function_pkg::RESP_OKAY);
    give_verdict();
  end
endmodule : pin_function_control_tb
bind pin_function_control pin_function_control_monitor u_pin_function_control_monitor (
  .clk(clk), .arst_n(arst_n), .int_reset_req(int_reset_req),
  .dbg_force_reset(dbg_force_reset), .sys_reset(sys_reset), .pa_out(pa_out),
  .pa_oe(pa_oe), .pa_pu(pa_pu), .irq_request(irq_request),
  .branch_pin_level(branch_pin_level), .background_mode(background_mode),
  .high_drive_en(high_drive_en));

// >>> pin_function_pkg.sv
// Constants for the pin-function control block
package pin_function_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_SYS_OPTIONS = 8'h00;
  localparam logic [7:0] OFS_PORT_DATA = 8'h04;
  localparam logic [7:0] OFS_PORT_DIR = 8'h08;
  localparam logic [7:0] OFS_PORT_PULLUP = 8'h0c;
  localparam logic [7:0] OFS_HIGH_DRIVE = 8'h10;
  localparam logic [7:0] OFS_DEBUG_TX = 8'h14;
  localparam logic [7:0] OFS_DEBUG_DIV = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  // Field positions in system_options_one
  localparam int DEBUG_PIN_ENABLE = 0;
  localparam int RESET_PIN_ENABLE = 1;
  localparam int CMP_OUT_ENABLE = 2;
  localparam int SERIAL_BUS_ENABLE = 3;
  // Field positions in status
  localparam int ST_BACKGROUND = 0;
  localparam int ST_SHARED_LEVEL = 1;
  localparam int ST_DEBUG_LEVEL = 2;
  localparam int ST_LINK_BUSY = 3;
  // Reset values
  localparam logic [3:0] SYS_OPTIONS_RESET = 4'h3;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [7:0] DEBUG_DIV_RESET = 8'h00;
  // Port A bit positions with special functions
  localparam int OD_DATA_BIT = 2;
  localparam int OD_CLOCK_BIT = 3;
  localparam int DEBUG_BIT = 4;
  localparam int SHARED_RESET_BIT = 5;
  // Debug link bit timing, in debug clock ticks
  localparam logic [3:0] BIT_TICKS_LAST = 4'hf;
  localparam logic [3:0] LOW_TICKS_ONE = 4'h4;
  localparam logic [3:0] LOW_TICKS_ZERO = 4'hd;
  localparam logic [2:0] BITS_LAST = 3'h7;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pin_function_pkg
